/* File: hw/fcb_pkg.sv */
// Package for the flag conditional branch unit
package fcb_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] INSTR_OFFSET = 12'h004;
  localparam logic [11:0] PC_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h00C;
  localparam logic [11:0] FLAGS_OFFSET = 12'h010;
  localparam logic [11:0] COUNT_OFFSET = 12'h014;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_LOADPC_BIT = 1;
  localparam int INSTR_COND_LSB = 8;
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_N_BIT = 2;
  localparam int FLAG_V_BIT = 3;
  localparam int FLAG_H_BIT = 5;
  localparam int FLAG_T_BIT = 6;
  localparam int PC_WIDTH = 16;
  localparam int OFFSET_WIDTH = 7;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // Cycle counts of one branch
  localparam logic [1:0] CYCLES_NOT_TAKEN = 2'h1;
  localparam logic [1:0] CYCLES_TAKEN = 2'h2;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    branch_on_carry_set,
    branch_on_negative,
    branch_on_nonnegative,
    branch_signed_ge,
    branch_signed_lt,
    branch_half_carry_set,
    branch_half_carry_clear,
    branch_transfer_bit_set,
    branch_transfer_bit_clear,
    branch_overflow_set,
    branch_overflow_clear
  } fcb_cond_t;
  typedef struct packed {
    logic [3:0] cond;
    logic [6:0] offset;
  } fcb_instr_t;
  typedef struct packed {
    logic       valid;
    logic [3:0] cond;
    logic [6:0] offset;
    logic [7:0] flags;
  } fcb_req_t;
endpackage

/* File: hw/fcb_cond_eval.sv */
// Branch condition evaluator
`timescale 1ns/1ps
module fcb_cond_eval (
  // Condition and status flags
  input wire logic [3:0] cond,
  input wire logic [7:0] flags,
  // Result
  output logic taken,
  output logic known
);
  logic c_f;
  logic n_f;
  logic v_f;
  logic h_f;
  logic t_f;
  assign c_f = flags[fcb_pkg::FLAG_C_BIT];
  assign n_f = flags[fcb_pkg::FLAG_N_BIT];
  assign v_f = flags[fcb_pkg::FLAG_V_BIT];
  assign h_f = flags[fcb_pkg::FLAG_H_BIT];
  assign t_f = flags[fcb_pkg::FLAG_T_BIT];
  always_comb begin
    known = 1'b1;
    case (fcb_pkg::fcb_cond_t'(cond))
      fcb_pkg::branch_on_carry_set: taken = c_f;
      fcb_pkg::branch_on_negative: taken = n_f;
      fcb_pkg::branch_on_nonnegative: taken = ~n_f;
      fcb_pkg::branch_signed_ge: taken = ~(n_f ^ v_f);
      fcb_pkg::branch_signed_lt: taken = n_f ^ v_f;
      fcb_pkg::branch_half_carry_set: taken = h_f;
      fcb_pkg::branch_half_carry_clear: taken = ~h_f;
      fcb_pkg::branch_transfer_bit_set: taken = t_f;
      fcb_pkg::branch_transfer_bit_clear: taken = ~t_f;
      fcb_pkg::branch_overflow_set: taken = v_f;
      fcb_pkg::branch_overflow_clear: taken = ~v_f;
      default: begin
        taken = 1'b0;
        known = 1'b0;
      end
    endcase
  end
endmodule

/* File: hw/fcb_branch_unit.sv */
// Flag conditional branch unit with APB register access
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module fcb_branch_unit #(
  parameter int PCW = fcb_pkg::PC_WIDTH,
  parameter int KW = fcb_pkg::OFFSET_WIDTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  input wire logic issue_valid,
  input wire logic [3:0] issue_cond,
  input wire logic [KW-1:0] issue_offset,
  input wire logic [7:0] status_flags,
  output logic busy,
  output logic fetch_flush,
  output logic done,
  output logic done_taken,
  output logic [PCW-1:0] pc
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  typedef enum {st_idle, st_flush} fcb_state_t;

  function automatic logic [PCW-1:0] fcb_target(input logic [PCW-1:0] base,
                                                input logic [KW-1:0] k,
                                                input logic tk);
    logic [PCW-1:0] ext;
    ext = {{(PCW-KW){k[KW-1]}}, k};
    if (tk) begin
      fcb_target = base + ext + {{(PCW-1){1'b0}}, 1'b1};
    end else begin
      fcb_target = base + {{(PCW-1){1'b0}}, 1'b1};
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  fcb_state_t state;
  fcb_state_t next_state;
  logic [PCW-1:0] next_pc;
  fcb_pkg::fcb_req_t req;
  logic [7:0] flags_seen;
  logic [7:0] next_flags_seen;
  logic next_done;
  logic next_done_taken;
  logic [15:0] branch_count;
  logic [15:0] next_branch_count;
  logic [15:0] taken_count;
  logic [15:0] next_taken_count;
  logic [3:0] sw_cond;
  logic [3:0] next_sw_cond;
  logic [KW-1:0] sw_offset;
  logic [KW-1:0] next_sw_offset;
  logic wr_en;
  logic rd_en;
  logic eval_taken;
  logic eval_known;
  logic [7:0] flags_in;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Request merge: core issue wins over software issue
  always_comb begin
    req.valid = 1'b0;
    req.cond = issue_cond;
    req.offset = issue_offset;
    req.flags = status_flags;
    if (state == st_idle && issue_valid) begin
      req.valid = 1'b1;
    end else if (state == st_idle && wr_en && paddr == fcb_pkg::CTRL_OFFSET &&
                 pwdata[fcb_pkg::CTRL_GO_BIT]) begin
      req.valid = 1'b1;
      req.cond = sw_cond;
      req.offset = sw_offset;
    end
  end

  assign flags_in = req.flags;

  fcb_cond_eval u_eval (
    .cond(req.cond),
    .flags(flags_in),
    .taken(eval_taken),
    .known(eval_known)
  );

  // ---------------------------------------------------------------
  // Branch sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_done = 1'b0;
    next_done_taken = 1'b0;
    next_flags_seen = flags_seen;
    next_branch_count = branch_count;
    next_taken_count = taken_count;
    case (state)
      st_idle: begin
        if (req.valid && eval_known) begin
          next_pc = fcb_target(pc, req.offset, eval_taken);
          next_flags_seen = req.flags;
          next_branch_count = branch_count + 16'h0001;
          if (eval_taken) begin
            next_state = st_flush;
            next_taken_count = taken_count + 16'h0001;
          end else begin
            next_done = 1'b1;
          end
        end else if (wr_en && paddr == fcb_pkg::PC_OFFSET) begin
          next_pc = pwdata[PCW-1:0];
        end
      end
      st_flush: begin
        next_state = st_idle;
        next_done = 1'b1;
        next_done_taken = 1'b1;
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      pc <= fcb_pkg::PC_RESET;
      done <= 1'b0;
      done_taken <= 1'b0;
      flags_seen <= fcb_pkg::FLAGS_RESET;
      branch_count <= 16'h0000;
      taken_count <= 16'h0000;
    end else begin
      state <= next_state;
      pc <= next_pc;
      done <= next_done;
      done_taken <= next_done_taken;
      flags_seen <= next_flags_seen;
      branch_count <= next_branch_count;
      taken_count <= next_taken_count;
    end
  end

  assign busy = (state == st_flush);
  assign fetch_flush = (state == st_flush);

  // ---------------------------------------------------------------
  // Software instruction register
  // ---------------------------------------------------------------
  always_comb begin
    next_sw_cond = sw_cond;
    next_sw_offset = sw_offset;
    if (wr_en && paddr == fcb_pkg::INSTR_OFFSET) begin
      next_sw_cond = pwdata[fcb_pkg::INSTR_COND_LSB +: 4];
      next_sw_offset = pwdata[KW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cond <= 4'h0;
      sw_offset <= '0;
    end else begin
      sw_cond <= next_sw_cond;
      sw_offset <= next_sw_offset;
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    prdata = fcb_pkg::UNMAPPED_READ;
    if (rd_en) begin
      case (paddr)
        fcb_pkg::INSTR_OFFSET: prdata = {20'h0_0000, sw_cond, 1'b0, sw_offset};
        fcb_pkg::PC_OFFSET: prdata = {{(32-PCW){1'b0}}, pc};
        fcb_pkg::STATUS_OFFSET: prdata = {30'h0000_0000, done_taken, busy};
        fcb_pkg::FLAGS_OFFSET: prdata = {24'h00_0000, flags_seen};
        fcb_pkg::COUNT_OFFSET: prdata = {taken_count, branch_count};
        default: prdata = fcb_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_taken_issue;
    state == st_idle && req.valid && eval_known && eval_taken;
  endsequence

  sequence s_flush_done;
    fetch_flush ##1 (done && done_taken);
  endsequence

  taken_two_cycles_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_taken_issue |=> s_flush_done)
    else $error("taken branch not two cycles");

  untaken_one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_idle && req.valid && eval_known && !eval_taken)
    |=> done && !done_taken && !busy)
    else $error("untaken branch not one cycle");

  pc_target_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_taken_issue |=> pc == PCW'($past(pc) + {{(PCW-KW){$past(req.offset[KW-1])}},
      $past(req.offset)} + 1))
    else $error("taken target wrong");

  pc_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_idle && req.valid && eval_known && !eval_taken)
    |=> pc == PCW'($past(pc) + 1))
    else $error("untaken step wrong");

  pc_hold_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy |=> pc == $past(pc) && !busy)
    else $error("counter moved in flush");

  invalid_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_idle && req.valid && !eval_known) |=> !done && !busy)
    else $error("invalid code not ignored");

  carry_cond_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_on_carry_set))
    |-> eval_taken == req.flags[fcb_pkg::FLAG_C_BIT])
    else $error("carry condition wrong");

  negative_cond_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_on_negative))
    |-> eval_taken == req.flags[fcb_pkg::FLAG_N_BIT])
    else $error("negative condition wrong");

  nonnegative_cond_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_on_nonnegative))
    |-> eval_taken == !req.flags[fcb_pkg::FLAG_N_BIT])
    else $error("nonnegative condition wrong");

  signed_ge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_signed_ge)) |-> eval_taken ==
    !(req.flags[fcb_pkg::FLAG_N_BIT] ^ req.flags[fcb_pkg::FLAG_V_BIT]))
    else $error("signed ge wrong");

  signed_lt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_signed_lt)) |-> eval_taken ==
    (req.flags[fcb_pkg::FLAG_N_BIT] ^ req.flags[fcb_pkg::FLAG_V_BIT]))
    else $error("signed lt wrong");

  half_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_half_carry_set))
    |-> eval_taken == req.flags[fcb_pkg::FLAG_H_BIT])
    else $error("half carry set wrong");

  half_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_half_carry_clear))
    |-> eval_taken == !req.flags[fcb_pkg::FLAG_H_BIT])
    else $error("half carry clear wrong");

  transfer_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_transfer_bit_set))
    |-> eval_taken == req.flags[fcb_pkg::FLAG_T_BIT])
    else $error("transfer set wrong");

  transfer_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_transfer_bit_clear))
    |-> eval_taken == !req.flags[fcb_pkg::FLAG_T_BIT])
    else $error("transfer clear wrong");

  overflow_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_overflow_set))
    |-> eval_taken == req.flags[fcb_pkg::FLAG_V_BIT])
    else $error("overflow set wrong");

  overflow_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.cond == 4'(fcb_pkg::branch_overflow_clear))
    |-> eval_taken == !req.flags[fcb_pkg::FLAG_V_BIT])
    else $error("overflow clear wrong");

  flags_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_idle && req.valid && eval_known) |=> flags_seen == $past(req.flags))
    else $error("flag snapshot wrong");
endmodule

/* File: verification/fcb_fetch_model.sv */
// Core-side model: issues branches and holds the status flags
`timescale 1ns/1ps
module fcb_fetch_model (
  // Clock
  input wire logic pclk,
  // From the unit
  input wire logic fetch_flush,
  input wire logic done,
  input wire logic done_taken,
  // To the unit
  output logic issue_valid,
  output logic [3:0] issue_cond,
  output logic [6:0] issue_offset,
  output logic [7:0] status_flags
);
  initial begin
    issue_valid = 1'h0;
    issue_cond = 4'hF;
    issue_offset = 7'h00;
    status_flags = 8'h00;
  end
  // ---------------------------------------------------------------
  // Issue one branch, report cycles, flush and taken
  // ---------------------------------------------------------------
  task automatic issue(input logic [3:0] c, input logic [6:0] k, input logic [7:0] f,
                       input bit hold2, output int cyc, output logic fl, output logic tk);
    issue_valid <= 1'h1;
    issue_cond <= c;
    issue_offset <= k;
    status_flags <= f;
    @(posedge pclk);
    if (!hold2) begin
      issue_valid <= 1'h0;
      issue_cond <= ~c;
      issue_offset <= ~k;
    end
    cyc = 0;
    fl = 1'h0;
    tk = 1'h0;
    do begin
      @(posedge pclk);
      cyc++;
      if (cyc == 1) begin
        fl = fetch_flush;
      end
      if (cyc == 1 && hold2) begin
        issue_valid <= 1'h0;
      end
      tk = done_taken;
    end while (done !== 1'h1 && cyc < 8);
  endtask
endmodule

/* File: verification/fcb_branch_unit_bench.sv */
// Self-checking bench for the flag conditional branch unit
`timescale 1ns/1ps
module fcb_branch_unit_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic issue_valid, fetch_flush, done, done_taken, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] issue_cond;
  logic [6:0] issue_offset;
  logic [7:0] status_flags;
  logic [15:0] pc, exp_pc;
  int num_errors = 0;
  int num_checks = 0;
  int n_br = 0;
  int n_tk = 0;

  fcb_branch_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .issue_valid(issue_valid), .issue_cond(issue_cond),
    .issue_offset(issue_offset), .status_flags(status_flags), .busy(busy),
    .fetch_flush(fetch_flush), .done(done), .done_taken(done_taken), .pc(pc));
  fcb_fetch_model i_core (.pclk(pclk), .fetch_flush(fetch_flush), .done(done),
    .done_taken(done_taken), .issue_valid(issue_valid), .issue_cond(issue_cond),
    .issue_offset(issue_offset), .status_flags(status_flags));

  // ---------------------------------------------------------------
  // Compare, bus and branch tasks
  // ---------------------------------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    check_val("pslverr", 32'h0000_0000, {31'h0000_0000, pslverr});
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  function automatic logic exp_take(input logic [3:0] c, input logic [7:0] f);
    logic nf, vf;
    nf = f[fcb_pkg::FLAG_N_BIT];
    vf = f[fcb_pkg::FLAG_V_BIT];
    case (c)
      4'h0: return f[fcb_pkg::FLAG_C_BIT];
      4'h1: return nf;
      4'h2: return !nf;
      4'h3: return !(nf ^ vf);
      4'h4: return nf ^ vf;
      4'h5: return f[fcb_pkg::FLAG_H_BIT];
      4'h6: return !f[fcb_pkg::FLAG_H_BIT];
      4'h7: return f[fcb_pkg::FLAG_T_BIT];
      4'h8: return !f[fcb_pkg::FLAG_T_BIT];
      4'h9: return vf;
      4'hA: return !vf;
      default: return 1'h0;
    endcase
  endfunction
  task automatic branch(input logic [3:0] c, input logic [6:0] k, input logic [7:0] f,
                        input bit hold2);
    int cyc;
    logic fl, tk, t;
    t = exp_take(c, f);
    i_core.issue(c, k, f, hold2, cyc, fl, tk);
    if (c <= 4'hA) begin
      exp_pc = t ? exp_pc + {{9{k[6]}}, k} + 16'h0001 : exp_pc + 16'h0001;
      n_br++;
      n_tk += t;
    end
    check_val("pc", {16'h0000, exp_pc}, {16'h0000, pc});
    check_val("cycles", c > 4'hA ? 32'h0000_0008 : t ? 32'h0000_0002 : 32'h0000_0001,
              32'(cyc));
    check_val("busy", 32'h0000_0000, {31'h0000_0000, busy});
    check_val("flush", {31'h0000_0000, t}, {31'h0000_0000, fl});
    check_val("taken", {31'h0000_0000, t}, {31'h0000_0000, tk}); // to
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    $display("watchdog expired");
    num_errors++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] pat [3];
    pat = '{8'h00, 8'h6D, 8'h04};
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, fcb_pkg::PC_OFFSET, 32'h0000_0000, rd);
    check_val("pc reset", {16'h0000, fcb_pkg::PC_RESET}, rd);
    apb(1'h0, fcb_pkg::STATUS_OFFSET, 32'h0000_0000, rd);
    check_val("status reset", 32'h0000_0000, rd);
    apb(1'h0, 12'h020, 32'h0000_0000, rd);
    check_val("unmapped", fcb_pkg::UNMAPPED_READ, rd);
    $display("test reset finished");
    apb(1'h1, fcb_pkg::PC_OFFSET, 32'h0000_1234, rd);
    exp_pc = 16'h1234;
    apb(1'h0, fcb_pkg::PC_OFFSET, 32'h0000_0000, rd);
    check_val("pc write", 32'h0000_1234, rd);
    $display("test pc write finished");
    for (int c = 0; c < 11; c++) begin
      for (int p = 0; p < 3; p++) begin
        branch(4'(c), 7'(c * 13 + p * 50), pat[p], 1'b0); // to
      end
    end
    $display("test conditions finished");
    apb(1'h0, fcb_pkg::FLAGS_OFFSET, 32'h0000_0000, rd);
    check_val("flags", {24'h00_0000, pat[2]}, rd);
    apb(1'h0, fcb_pkg::COUNT_OFFSET, 32'h0000_0000, rd);
    check_val("count", {16'(n_tk), 16'(n_br)}, rd);
    apb(1'h1, fcb_pkg::INSTR_OFFSET, 32'h0000_047E, rd);
    apb(1'h0, fcb_pkg::INSTR_OFFSET, 32'h0000_0000, rd);
    check_val("instr", 32'h0000_047E, rd);
    apb(1'h1, fcb_pkg::CTRL_OFFSET, 32'h0000_0001, rd);
    exp_pc = exp_pc + 16'hFFFF;
    apb(1'h0, fcb_pkg::PC_OFFSET, 32'h0000_0000, rd);
    check_val("sw pc", {16'h0000, exp_pc}, rd);
    $display("test register issue finished");
    branch(4'h0, 7'h40, 8'h01, 1'b1);
    branch(4'hB, 7'h05, 8'h6D, 1'b0);
    $display("test busy and invalid finished");
    tally_and_finish();
  end
endmodule
